// File: src/vcpu_ctrl_pkg.sv
// Package for the virtual CPU interface control and capability registers.
// Assumes a single core clock domain and a coprocessor access port.
package vcpu_ctrl_pkg;
    // System-register encodings (opc1, CRn, CRm, opc2) on coprocessor 15.
    localparam logic [3:0] coproc_num = 4'hf;
    localparam logic [2:0] acc_opc1 = 3'h4;
    localparam logic [3:0] acc_crn = 4'hc;
    localparam logic [3:0] acc_crm = 4'hb;
    localparam logic [2:0] opc2_control = 3'h7;
    localparam logic [2:0] opc2_capability = 3'h1;

    // Control register field positions.
    localparam int pmask_lsb = 24;
    localparam int bp0_lsb = 21;
    localparam int bp1_lsb = 18;
    localparam int eoim_bit = 9;
    localparam int cbpr_bit = 4;
    localparam int fiq_bit = 3;
    localparam int ack_bit = 2;
    localparam int grp1_bit = 1;
    localparam int grp0_bit = 0;
    localparam logic [31:0] control_reset = 32'h0000_0000;
    localparam logic [31:0] control_write_mask = 32'hfffc_021f;

    // Capability register field positions.
    localparam int pri_lsb = 29;
    localparam int pre_lsb = 26;
    localparam int idw_lsb = 23;
    localparam int serror_gen_support_bit = 22;
    localparam int a3v_bit = 21;
    localparam int nodi_bit = 20;
    localparam int tds_bit = 19;
    localparam int lrc_lsb = 0;

    localparam logic [2:0] idw_16 = 3'h0;
    localparam logic [2:0] idw_24 = 3'h1;
    localparam logic [2:0] bp_saturate = 3'h7;
    localparam logic [23:0] ack_spurious_id = 24'h0003fe;

    // Exception levels and access outcomes.
    typedef enum logic [1:0] {el0 = 2'h0, el1 = 2'h1, el2 = 2'h2, el3 = 2'h3} level_t;
    typedef enum logic [2:0] {
        res_ok = 3'h1,
        res_undef = 3'h2,
        res_trap = 3'h4
    } result_t;
endpackage : vcpu_ctrl_pkg

// File: src/vcpu_access_check.sv
// Privilege and trap checker for one coprocessor access to these registers.
// Assumes the inputs are stable on the same clock as the caller.
`timescale 1ns/100ps
module vcpu_access_check
(
    input wire logic [1:0] level,
    input wire logic non_secure,
    input wire logic hyp_present,
    input wire logic hyp_sysreg_enable,
    input wire logic monitor_sysreg_enable,
    input wire logic hyp_cp12_trap,
    output vcpu_ctrl_pkg::result_t result
);
    always_comb
    begin
        result = vcpu_ctrl_pkg::res_undef;
        unique case (level)
            2'h2:
            begin
                if (!hyp_present || !non_secure || !hyp_sysreg_enable)
                    result = vcpu_ctrl_pkg::res_undef;
                else
                    result = vcpu_ctrl_pkg::res_ok;
            end
            2'h3:
            begin
                if (non_secure && !monitor_sysreg_enable)
                    result = vcpu_ctrl_pkg::res_undef;
                else
                    result = vcpu_ctrl_pkg::res_ok;
            end
            2'h1:
            begin
                if (hyp_present && non_secure && hyp_cp12_trap)
                    result = vcpu_ctrl_pkg::res_trap;
                else
                    result = vcpu_ctrl_pkg::res_undef;
            end
            2'h0:
                result = vcpu_ctrl_pkg::res_undef;
        endcase
    end
endmodule : vcpu_access_check

// File: src/vcpu_iface_ctrl.sv
// Virtual CPU interface control register and capability register with
// the guest-visible effects of the control fields.
// Assumes one coprocessor access per valid pulse and inputs on mclk.
`timescale 1ns/100ps

module vcpu_iface_ctrl
#(
    parameter logic [2:0] priority_bit_count = 3'h4,
    parameter logic [2:0] preempt_bit_count = 3'h4,
    parameter logic [2:0] identifier_width = 3'h0,
    parameter logic serror_gen_support = 1'b0,
    parameter logic aff_level3_valid = 1'b0,
    parameter logic no_direct_injection = 1'b1,
    parameter logic deact_trap_supported = 1'b0,
    parameter logic [4:0] list_reg_count = 5'h03,
    parameter logic hyp_present = 1'b1
)
(
    input wire logic mclk,
    input wire logic reset,
    // Hypervisor coprocessor access.
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [3:0] acc_coproc,
    input wire logic [2:0] acc_op1,
    input wire logic [3:0] acc_n,
    input wire logic [3:0] acc_m,
    input wire logic [2:0] acc_op2,
    input wire logic [1:0] acc_level,
    input wire logic acc_non_secure,
    input wire logic [31:0] acc_wdata,
    input wire logic hyp_sysreg_enable,
    input wire logic monitor_sysreg_enable,
    input wire logic hyp_cp12_trap,
    output logic acc_done,
    output logic acc_undef,
    output logic acc_trap,
    output logic [31:0] acc_rdata,
    // Guest-side virtual interface access.
    input wire logic guest_valid,
    input wire logic guest_write,
    input wire logic guest_sel_bp1,
    input wire logic [2:0] guest_wdata,
    output logic [2:0] guest_rdata,
    output logic guest_done,
    // Pending interrupt presentation.
    input wire logic pend_valid,
    input wire logic pend_grp1,
    input wire logic [7:0] pend_priority,
    input wire logic [23:0] pend_id,
    output logic virt_irq,
    output logic virt_fiq,
    output logic [23:0] ack_id,
    output logic [7:0] preempt_group_mask,
    // End of interrupt and deactivate requests.
    input wire logic eoi_write,
    input wire logic deact_write,
    output logic prio_drop,
    output logic deactivate
);
    logic [7:0] virt_priority_mask;
    logic [2:0] virt_binary_point_grp0;
    logic [2:0] virt_binary_point_grp1;
    logic virt_eoi_mode;
    logic virt_common_binary_point;
    logic virt_fiq_enable;
    logic virt_ack_control;
    logic virt_grp1_enable;
    logic virt_grp0_enable;
    vcpu_ctrl_pkg::result_t check;
    logic sel_control;
    logic sel_capability;
    logic [31:0] control_word;
    logic [31:0] capability_word;
    logic [2:0] bp1_view;
    logic [2:0] active_point;
    logic deliver;

    function automatic logic [2:0] sat_inc(input logic [2:0] value);
        if (value == vcpu_ctrl_pkg::bp_saturate)
            return vcpu_ctrl_pkg::bp_saturate;
        return 3'(value + 3'h1);
    endfunction : sat_inc

    function automatic logic [7:0] point_mask(input logic [2:0] point);
        return 8'(8'hfe << point);
    endfunction : point_mask

    vcpu_access_check u_check
    (
        .level(acc_level),
        .non_secure(acc_non_secure),
        .hyp_present(hyp_present),
        .hyp_sysreg_enable(hyp_sysreg_enable),
        .monitor_sysreg_enable(monitor_sysreg_enable),
        .hyp_cp12_trap(hyp_cp12_trap),
        .result(check)
    );

    assign sel_control = acc_coproc == vcpu_ctrl_pkg::coproc_num
        && acc_op1 == vcpu_ctrl_pkg::acc_opc1 && acc_n == vcpu_ctrl_pkg::acc_crn
        && acc_m == vcpu_ctrl_pkg::acc_crm && acc_op2 == vcpu_ctrl_pkg::opc2_control;
    assign sel_capability = acc_coproc == vcpu_ctrl_pkg::coproc_num
        && acc_op1 == vcpu_ctrl_pkg::acc_opc1 && acc_n == vcpu_ctrl_pkg::acc_crn
        && acc_m == vcpu_ctrl_pkg::acc_crm && acc_op2 == vcpu_ctrl_pkg::opc2_capability;

    // Fields pack at their documented positions; gaps stay zero.
    always_comb
    begin
        control_word = 32'h0000_0000;
        control_word[vcpu_ctrl_pkg::pmask_lsb +: 8] = virt_priority_mask;
        control_word[vcpu_ctrl_pkg::bp0_lsb +: 3] = virt_binary_point_grp0;
        control_word[vcpu_ctrl_pkg::bp1_lsb +: 3] = virt_binary_point_grp1;
        control_word[vcpu_ctrl_pkg::eoim_bit] = virt_eoi_mode;
        control_word[vcpu_ctrl_pkg::cbpr_bit] = virt_common_binary_point;
        control_word[vcpu_ctrl_pkg::fiq_bit] = virt_fiq_enable;
        control_word[vcpu_ctrl_pkg::ack_bit] = virt_ack_control;
        control_word[vcpu_ctrl_pkg::grp1_bit] = virt_grp1_enable;
        control_word[vcpu_ctrl_pkg::grp0_bit] = virt_grp0_enable;
    end

    always_comb
    begin
        capability_word = 32'h0000_0000;
        if (hyp_present)
        begin
            capability_word[vcpu_ctrl_pkg::pri_lsb +: 3] = priority_bit_count;
            capability_word[vcpu_ctrl_pkg::pre_lsb +: 3] = preempt_bit_count;
            capability_word[vcpu_ctrl_pkg::idw_lsb +: 3] = identifier_width;
            capability_word[vcpu_ctrl_pkg::serror_gen_support_bit] = serror_gen_support;
            capability_word[vcpu_ctrl_pkg::a3v_bit] = aff_level3_valid;
            capability_word[vcpu_ctrl_pkg::nodi_bit] = no_direct_injection;
            capability_word[vcpu_ctrl_pkg::tds_bit] = deact_trap_supported;
            capability_word[vcpu_ctrl_pkg::lrc_lsb +: 5] = list_reg_count;
        end
        else
            capability_word[vcpu_ctrl_pkg::nodi_bit] = 1'b1;
    end

    // Hypervisor access response; a write to the capability register is undefined.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            acc_done <= 1'b0;
            acc_undef <= 1'b0;
            acc_trap <= 1'b0;
            acc_rdata <= 32'h0000_0000;
        end
        else
        begin
            acc_done <= acc_valid;
            acc_undef <= 1'b0;
            acc_trap <= 1'b0;
            acc_rdata <= 32'h0000_0000;
            if (acc_valid)
            begin
                if (!(sel_control || sel_capability) || (sel_capability && acc_write))
                    acc_undef <= 1'b1;
                else if (check == vcpu_ctrl_pkg::res_trap)
                    acc_trap <= 1'b1;
                else if (check == vcpu_ctrl_pkg::res_undef)
                    acc_undef <= 1'b1;
                else if (!acc_write)
                    acc_rdata <= sel_control ? control_word : capability_word;
            end
        end
    end

    logic hyp_wr;
    logic [31:0] wmasked;
    assign hyp_wr = acc_valid && acc_write && sel_control && check == vcpu_ctrl_pkg::res_ok;
    assign wmasked = acc_wdata & vcpu_ctrl_pkg::control_write_mask;

    // Guest binary point writes share the fields with the hypervisor; hypervisor wins.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            virt_binary_point_grp0 <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::bp0_lsb +: 3];
            virt_binary_point_grp1 <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::bp1_lsb +: 3];
        end
        else if (hyp_wr)
        begin
            virt_binary_point_grp0 <= wmasked[vcpu_ctrl_pkg::bp0_lsb +: 3];
            virt_binary_point_grp1 <= wmasked[vcpu_ctrl_pkg::bp1_lsb +: 3];
        end
        else if (guest_valid && guest_write)
        begin
            if (!guest_sel_bp1)
                virt_binary_point_grp0 <= guest_wdata;
            else if (!virt_common_binary_point)
                virt_binary_point_grp1 <= guest_wdata;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            virt_priority_mask <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::pmask_lsb +: 8];
            virt_eoi_mode <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::eoim_bit];
            virt_common_binary_point <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::cbpr_bit];
            virt_fiq_enable <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::fiq_bit];
            virt_ack_control <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::ack_bit];
            virt_grp1_enable <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::grp1_bit];
            virt_grp0_enable <= vcpu_ctrl_pkg::control_reset[vcpu_ctrl_pkg::grp0_bit];
        end
        else if (hyp_wr)
        begin
            virt_priority_mask <= wmasked[vcpu_ctrl_pkg::pmask_lsb +: 8];
            virt_eoi_mode <= wmasked[vcpu_ctrl_pkg::eoim_bit];
            virt_common_binary_point <= wmasked[vcpu_ctrl_pkg::cbpr_bit];
            virt_fiq_enable <= wmasked[vcpu_ctrl_pkg::fiq_bit];
            virt_ack_control <= wmasked[vcpu_ctrl_pkg::ack_bit];
            virt_grp1_enable <= wmasked[vcpu_ctrl_pkg::grp1_bit];
            virt_grp0_enable <= wmasked[vcpu_ctrl_pkg::grp0_bit];
        end
    end

    assign bp1_view = virt_common_binary_point ? sat_inc(virt_binary_point_grp0)
        : virt_binary_point_grp1;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            guest_done <= 1'b0;
            guest_rdata <= 3'h0;
        end
        else
        begin
            guest_done <= guest_valid;
            if (guest_valid && !guest_write)
                guest_rdata <= guest_sel_bp1 ? bp1_view : virt_binary_point_grp0;
        end
    end

    // Group 1 uses its own point unless the common bit hands it to Group 0.
    assign active_point = (pend_grp1 && !virt_common_binary_point)
        ? virt_binary_point_grp1 : virt_binary_point_grp0;
    assign deliver = pend_valid && pend_priority < virt_priority_mask
        && (pend_grp1 ? virt_grp1_enable : virt_grp0_enable);

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            virt_irq <= 1'b0;
            virt_fiq <= 1'b0;
            ack_id <= 24'h000000;
            preempt_group_mask <= 8'h00;
        end
        else
        begin
            virt_fiq <= deliver && !pend_grp1 && virt_fiq_enable;
            virt_irq <= deliver && (pend_grp1 || !virt_fiq_enable);
            preempt_group_mask <= point_mask(active_point);
            if (pend_valid && pend_grp1 && !virt_ack_control)
                ack_id <= vcpu_ctrl_pkg::ack_spurious_id;
            else
                ack_id <= pend_valid ? pend_id : 24'h000000;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            prio_drop <= 1'b0;
            deactivate <= 1'b0;
        end
        else
        begin
            prio_drop <= eoi_write;
            deactivate <= virt_eoi_mode ? deact_write : eoi_write;
        end
    end
endmodule : vcpu_iface_ctrl

// File: dv/vcpu_iface_ctrl_asserts.sv
// Checker for the virtual interface control block, watching its ports only.
// Assumes the default capability parameters of the block it is bound to.
`timescale 1ns/100ps
module vcpu_iface_ctrl_chk
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [2:0] acc_op2,
    input wire logic [1:0] acc_level,
    input wire logic acc_non_secure,
    input wire logic hyp_sysreg_enable,
    input wire logic hyp_cp12_trap,
    input wire logic acc_done,
    input wire logic acc_undef,
    input wire logic acc_trap,
    input wire logic [31:0] acc_rdata,
    input wire logic guest_valid,
    input wire logic guest_done,
    input wire logic pend_valid,
    input wire logic virt_irq,
    input wire logic virt_fiq,
    input wire logic eoi_write,
    input wire logic deact_write,
    input wire logic prio_drop,
    input wire logic deactivate
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    AST_DONE_NEXT: assert property (acc_valid |=> acc_done)
        else $error("access not answered next cycle");
    AST_DONE_CAUSE: assert property (acc_done |-> $past(acc_valid))
        else $error("access answer without request");
    AST_EL0_UNDEF: assert property (acc_valid && acc_level == 2'h0
        |=> acc_undef && !acc_trap)
        else $error("lowest level access not refused");
    // A write to the read-only capability encoding is refused before any trap.
    AST_EL1_TRAP: assert property (acc_valid && acc_level == 2'h1 && acc_non_secure
        && hyp_cp12_trap && !(acc_write && acc_op2 == 3'h1) |=> acc_trap && !acc_undef)
        else $error("guest kernel access not trapped");
    AST_HYP_SRE: assert property (acc_valid && acc_level == 2'h2 && !hyp_sysreg_enable
        |=> acc_undef)
        else $error("hypervisor access with enable clear not refused");
    AST_REFUSED_ZERO: assert property (acc_done && (acc_undef || acc_trap)
        |-> acc_rdata == 32'h0)
        else $error("refused access returned data");
    AST_CAP_READ: assert property (acc_valid && !acc_write && acc_op2 == 3'h1
        && acc_level == 2'h3 && !acc_non_secure |=> acc_rdata == 32'h9010_0003)
        else $error("capability read wrong");
    AST_NO_PEND: assert property (!pend_valid |=> !virt_irq && !virt_fiq)
        else $error("interrupt line without pending interrupt");
    AST_ONE_LINE: assert property (!(virt_irq && virt_fiq))
        else $error("both interrupt lines raised");
    AST_EOI_DROP: assert property (eoi_write |=> prio_drop)
        else $error("end of interrupt without priority drop");
    AST_DEACT_CAUSE: assert property (deactivate
        |-> $past(eoi_write) || $past(deact_write))
        else $error("deactivate without request");
    AST_GUEST_DONE: assert property (guest_valid |=> guest_done)
        else $error("guest access not answered");
endmodule : vcpu_iface_ctrl_chk

bind vcpu_iface_ctrl vcpu_iface_ctrl_chk watch (.mclk, .reset, .acc_valid, .acc_write, .acc_op2,
    .acc_level, .acc_non_secure, .hyp_sysreg_enable, .hyp_cp12_trap, .acc_done, .acc_undef,
    .acc_trap, .acc_rdata, .guest_valid, .guest_done, .pend_valid, .virt_irq, .virt_fiq,
    .eoi_write, .deact_write, .prio_drop, .deactivate);

// File: dv/tb.sv
// Self-checking bench for the virtual interface control block.
// Assumes default capability parameters and a 125 MHz core clock.
`timescale 1ns/100ps
module tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic acc_valid = 1'b0, acc_write = 1'b0, acc_non_secure = 1'b0;
    logic [3:0] acc_coproc = 4'hf, acc_n = 4'hc, acc_m = 4'hb;
    logic [2:0] acc_op1 = 3'h4, acc_op2 = 3'h7, guest_wdata = 3'h0, guest_rdata;
    logic [1:0] acc_level = 2'h0, e;
    logic [31:0] acc_wdata = 32'h0, acc_rdata, ctl, r, wd;
    logic hyp_sysreg_enable = 1'b1, monitor_sysreg_enable = 1'b1, hyp_cp12_trap = 1'b0;
    logic guest_valid = 1'b0, guest_write = 1'b0, guest_sel_bp1 = 1'b0;
    logic pend_valid = 1'b0, pend_grp1 = 1'b0, eoi_write = 1'b0, deact_write = 1'b0;
    logic [7:0] pend_priority = 8'h0, preempt_group_mask, pr;
    logic [23:0] pend_id = 24'h0, ack_id;
    logic acc_done, acc_undef, acc_trap, guest_done, virt_irq, virt_fiq, prio_drop, deactivate;
    int err_count = 0;
    int checked = 0;

    always #4 mclk = ~mclk;

    vcpu_iface_ctrl DUT (.mclk, .reset, .acc_valid, .acc_write, .acc_coproc, .acc_op1, .acc_n,
        .acc_m, .acc_op2, .acc_level, .acc_non_secure, .acc_wdata, .hyp_sysreg_enable,
        .monitor_sysreg_enable, .hyp_cp12_trap, .acc_done, .acc_undef, .acc_trap, .acc_rdata,
        .guest_valid, .guest_write, .guest_sel_bp1, .guest_wdata, .guest_rdata, .guest_done,
        .pend_valid, .pend_grp1, .pend_priority, .pend_id, .virt_irq, .virt_fiq, .ack_id,
        .preempt_group_mask, .eoi_write, .deact_write, .prio_drop, .deactivate);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic acc(input logic wr, input logic [2:0] op2, input logic [1:0] lvl,
        input logic ns, input logic [31:0] d);
        @(posedge mclk);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_op2 <= op2;
        acc_level <= lvl;
        acc_non_secure <= ns;
        acc_wdata <= d;
        @(posedge mclk);
        acc_valid <= 1'b0;
        #1;
        chk("acc_done", 32'h1, {31'h0, acc_done});
    endtask : acc

    task automatic wctl(input logic [31:0] d);
        acc(1'b1, 3'h7, 2'h3, 1'b0, d);
        ctl = d & 32'hfffc_021f;
    endtask : wctl

    task automatic gst(input logic wr, input logic sel, input logic [2:0] d);
        @(posedge mclk);
        guest_valid <= 1'b1;
        guest_write <= wr;
        guest_sel_bp1 <= sel;
        guest_wdata <= d;
        @(posedge mclk);
        guest_valid <= 1'b0;
        #1;
        chk("guest_done", 32'h1, {31'h0, guest_done});
    endtask : gst

    // Returns the refusal pair as undefined then trapped.
    function automatic logic [1:0] exp_res(input logic wr, input logic [2:0] op2,
        input logic [1:0] lvl, input logic ns);
        if (wr && op2 == 3'h1)
            return 2'b10;
        if (lvl == 2'h1 && ns && hyp_cp12_trap)
            return 2'b01;
        if (lvl < 2'h2 || (lvl == 2'h2 && (!ns || !hyp_sysreg_enable))
            || (lvl == 2'h3 && ns && !monitor_sysreg_enable))
            return 2'b10;
        return 2'b00;
    endfunction : exp_res

    // Returns the interrupt lines as irq then fiq.
    function automatic logic [1:0] exp_line(input logic v, input logic g1, input logic [7:0] p);
        if (!v || p >= ctl[31:24])
            return 2'b00;
        if (g1)
            return {ctl[1], 1'b0};
        return {ctl[0] & !ctl[3], ctl[0] & ctl[3]};
    endfunction : exp_line

    initial
    begin
        #400000;
        err_count++;
        close_out;
    end

    initial
    begin
        void'($urandom(32'hbf31fc3f));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        acc(1'b0, 3'h7, 2'h3, 1'b0, 32'h0);
        chk("control reset", 32'h0, acc_rdata);
        ctl = 32'h0;
        @(posedge mclk);
        acc_m <= 4'ha;
        acc(1'b1, 3'h7, 2'h3, 1'b0, 32'hffff_ffff);
        chk("bad encoding", 32'h2, {30'h0, acc_undef, acc_trap});
        @(posedge mclk);
        acc_m <= 4'hb;
        repeat (60)
        begin
            r = $urandom;
            wd = $urandom;
            @(posedge mclk);
            hyp_sysreg_enable <= r[0];
            monitor_sysreg_enable <= r[1];
            hyp_cp12_trap <= r[2];
            acc(r[3], r[4] ? 3'h1 : 3'h7, r[6:5], r[7], wd);
            e = exp_res(r[3], acc_op2, r[6:5], r[7]);
            chk("refusal", {30'h0, e}, {30'h0, acc_undef, acc_trap});
            if (e == 2'b00 && r[3])
                ctl = wd & 32'hfffc_021f;
            else if (e == 2'b00)
                chk("read data", r[4] ? 32'h9010_0003 : ctl, acc_rdata);
            else
                chk("refused data", 32'h0, acc_rdata);
        end
        wctl(32'h00a8_0000);
        gst(1'b0, 1'b1, 3'h0);
        chk("bp1 own", 32'h2, {29'h0, guest_rdata});
        gst(1'b1, 1'b1, 3'h6);
        acc(1'b0, 3'h7, 2'h3, 1'b0, 32'h0);
        chk("bp1 alias", 32'h00b8_0000, acc_rdata);
        gst(1'b1, 1'b0, 3'h3);
        acc(1'b0, 3'h7, 2'h3, 1'b0, 32'h0);
        chk("bp0 alias", 32'h0078_0000, acc_rdata);
        gst(1'b0, 1'b0, 3'h0);
        chk("bp0 guest", 32'h3, {29'h0, guest_rdata});
        for (int b = 0; b < 8; b++)
        begin
            wctl(32'h0008_0010 | (b << 21));
            gst(1'b1, 1'b1, 3'h5);
            gst(1'b0, 1'b1, 3'h0);
            chk("bp1 common", (b == 7) ? 32'h7 : b + 1, {29'h0, guest_rdata});
            acc(1'b0, 3'h7, 2'h3, 1'b0, 32'h0);
            chk("bp1 kept", ctl, acc_rdata);
        end
        repeat (40)
        begin
            wctl($urandom);
            r = $urandom;
            pr = r[2] ? ctl[31:24] - {7'h0, r[3]} : r[15:8];
            @(posedge mclk);
            pend_valid <= r[0];
            pend_grp1 <= r[1];
            pend_priority <= pr;
            pend_id <= r[31:8];
            @(posedge mclk);
            #1;
            chk("lines", {30'h0, exp_line(r[0], r[1], pr)},
                {30'h0, virt_irq, virt_fiq});
            chk("ack id", !r[0] ? 32'h0 : (r[1] && !ctl[2]) ? 32'd1022 : {8'h0, r[31:8]},
                {8'h0, ack_id});
            if (r[0])
                chk("preempt mask",
                    {24'h0, 8'hfe << ((r[1] && !ctl[4]) ? ctl[20:18] : ctl[23:21])},
                    {24'h0, preempt_group_mask});
        end
        for (int m = 0; m < 4; m++)
        begin
            wctl({22'h0, m[0], 9'h0});
            @(posedge mclk);
            pend_valid <= 1'b0;
            eoi_write <= !m[1];
            deact_write <= m[1];
            @(posedge mclk);
            eoi_write <= 1'b0;
            deact_write <= 1'b0;
            #1;
            chk("eoi effects", {30'h0, !m[1], m[1] ? m[0] : !m[0]},
                {30'h0, prio_drop, deactivate});
        end
        close_out;
    end
endmodule : tb
